// >>> design/pbw_consts.svh
// pbw_consts.svh: offsets, field positions, reset values and command codes
// for the posted write forwarding block; assumes nothing of its includer
`ifndef PBW_CONSTS_SVH
`define PBW_CONSTS_SVH
`define PBW_OFS_CHIP_CTRL 12'h044
`define PBW_OFS_LINE_SIZE 12'h00C
`define PBW_OFS_WI_CTRL 12'h074
`define PBW_OFS_STATUS 12'h078
`define PBW_BIT_DISC_LINE 1
`define PBW_WI_LSB 7
`define PBW_WI_MSB 8
`define PBW_RST_CHIP_CTRL 32'h0000_0000
`define PBW_RST_WI_CTRL 32'h0000_0000
`define PBW_RST_LINE_SIZE 8'h00
`define PBW_CMD_MEMWR 4'h7
`define PBW_CMD_MWI 4'hF
`define PBW_BUF_BYTES 128
`define PBW_PAGE_DWORDS 1024
`endif

// >>> design/pbw_pkg.sv
// pbw_pkg.sv: types for the posted write forwarding block
// assumes pbw_consts.svh is compiled alongside
`default_nettype none
package pbw_pkg;
  typedef enum logic [1:0] {
    PBW_TI_IDLE = 2'b00,
    PBW_TI_DATA = 2'b01,
    PBW_TI_TURN = 2'b10
  } pbw_tgt_t;
  typedef enum logic [1:0] {
    PBW_MI_IDLE = 2'b00,
    PBW_MI_ADDR = 2'b01,
    PBW_MI_DATA = 2'b10,
    PBW_MI_TURN = 2'b11
  } pbw_mst_t;
endpackage
`default_nettype wire

// >>> design/pbw_bridge.sv
// pbw_bridge.sv: posted memory write path of a two-port bus bridge, one direction,
// initiator-bus target side, posted queue and target-bus master side, plus APB registers.
// assumes both buses share SYS_CLK; bus pins already two-flop synchronised is not needed
// since they share the clock, but raw pins are still registered once through two flops.
//
// Added by the designer: the APB interface to the registers.
`default_nettype none
`include "pbw_consts.svh"
module pbw_bridge
  import pbw_pkg::*;
#(
  parameter int DEPTH = `PBW_BUF_BYTES / 4,
  parameter logic [31:0] WIN_BASE = 32'h8000_0000,
  parameter logic [31:0] WIN_LIMIT = 32'h8FFF_FFFF,
  parameter logic [31:0] VGA_BASE = 32'h000A_0000,
  parameter logic [31:0] VGA_LIMIT = 32'h000B_FFFF,
  parameter int LAT_TIMER = 32
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [31:0] I_AD,
  input wire logic [3:0] I_COMMAND_BYTE_ENABLE,
  input wire logic I_FRAME_N,
  input wire logic I_IRDY_N,
  output logic I_DEVSEL_N_O,
  output logic I_TRDY_N_O,
  output logic I_STOP_N_O,
  output logic I_CTL_OE,
  output logic [31:0] T_AD_O,
  output logic [3:0] T_COMMAND_BYTE_ENABLE_O,
  output logic T_AD_OE,
  output logic T_FRAME_N_O,
  output logic T_IRDY_N_O,
  output logic T_CTL_OE,
  output logic T_REQ_N,
  input wire logic T_GNT_N,
  input wire logic T_FRAME_N,
  input wire logic T_IRDY_N,
  input wire logic T_TRDY_N,
  input wire logic T_STOP_N,
  input wire logic T_DEVSEL_N
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("DEPTH must be a power of two from 2 to 256");
    end
  end

  // pin synchronisers: stage one is read only by stage two
  logic [31:0] ad_s1, ad;
  logic [3:0] cbe_s1, cbe;
  logic [4:0] ic_s1, ic;
  logic [5:0] tc_s1, tc;
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ad_s1 <= 32'h0000_0000;
      ad <= 32'h0000_0000;
      cbe_s1 <= 4'hF;
      cbe <= 4'hF;
      ic_s1 <= 5'h03;
      ic <= 5'h03;
      tc_s1 <= 6'h3F;
      tc <= 6'h3F;
    end else begin
      ad_s1 <= I_AD;
      ad <= ad_s1;
      cbe_s1 <= I_COMMAND_BYTE_ENABLE;
      cbe <= cbe_s1;
      ic_s1 <= {3'b000, I_FRAME_N, I_IRDY_N};
      ic <= ic_s1;
      tc_s1 <= {T_GNT_N, T_FRAME_N, T_IRDY_N, T_TRDY_N, T_STOP_N, T_DEVSEL_N};
      tc <= tc_s1;
    end
  end
  wire i_frame = !ic[1];
  wire i_irdy = !ic[0];
  wire t_gnt = !tc[5];
  wire t_idle = tc[4] && tc[3];
  wire t_trdy = !tc[2];
  wire t_stop = !tc[1];
  wire t_devsel = !tc[0];

  // registers
  logic [31:0] chip_ctrl, wi_ctrl;
  logic [7:0] line_size;
  logic abort_seen;
  wire acc = PSEL && PENABLE;
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      chip_ctrl <= `PBW_RST_CHIP_CTRL;
      wi_ctrl <= `PBW_RST_WI_CTRL;
      line_size <= `PBW_RST_LINE_SIZE;
    end else if (acc && PWRITE) begin
      case (PADDR)
        `PBW_OFS_CHIP_CTRL: chip_ctrl <= PWDATA;
        `PBW_OFS_WI_CTRL: wi_ctrl <= PWDATA;
        `PBW_OFS_LINE_SIZE: line_size <= PWDATA[7:0];
        default: begin
        end
      endcase
    end
  end
  assign PREADY = 1'b1;
  always_comb begin
    case (PADDR)
      `PBW_OFS_CHIP_CTRL: PSLVERR = 1'b0;
      `PBW_OFS_WI_CTRL: PSLVERR = 1'b0;
      `PBW_OFS_LINE_SIZE: PSLVERR = 1'b0;
      `PBW_OFS_STATUS: PSLVERR = 1'b0;
      default: PSLVERR = acc;
    endcase
  end

  // posted queue: one entry per dword, a start flag marks a new transaction's address
  logic [31:0] q_data [DEPTH];
  logic [3:0] q_be [DEPTH];
  logic [DEPTH-1:0] q_start;
  logic [31:0] q_addr [DEPTH];
  logic [3:0] q_cmd [DEPTH];
  logic [AW:0] wp, rp;
  wire [AW:0] used = wp - rp;
  wire q_empty = used == '0;
  wire q_full = used == (AW + 1)'(DEPTH);
  wire q_last_room = used == (AW + 1)'(DEPTH - 1);

  // target side
  pbw_tgt_t ti;
  logic [31:0] cur_addr;
  logic [3:0] cur_cmd;
  logic nonlin, first_put, disc;
  logic ti_devsel, ti_trdy;
  wire [3:0] c = cbe;
  wire is_memwr = c == `PBW_CMD_MEMWR;
  wire is_mwi = c == `PBW_CMD_MWI;
  wire in_win = ad >= WIN_BASE && ad <= WIN_LIMIT;
  wire in_vga = ad >= VGA_BASE && ad <= VGA_LIMIT;
  // reserved, interrupt ack, special cycle, type 0 config and delayed writes are never claimed here
  wire claim = i_frame && !q_full && in_win && ((is_memwr && !in_vga) || is_mwi);
  wire line_ok = line_size == 8'd1 || line_size == 8'd2 || line_size == 8'd4 ||
                 line_size == 8'd8 || line_size == 8'd16;
  wire [1:0] wi_fld = wi_ctrl[`PBW_WI_MSB:`PBW_WI_LSB];
  wire mwi_line = wi_fld == 2'b11 && line_ok;
  wire use_line = (cur_cmd == `PBW_CMD_MWI) ? mwi_line : chip_ctrl[`PBW_BIT_DISC_LINE];
  wire [9:0] dw = cur_addr[11:2];
  wire [9:0] lmask = 10'(line_size) - 10'd1;
  wire at_bound = use_line ? ((dw & lmask) == lmask) : (dw == 10'h3FF);
  wire xfer_in = ti == PBW_TI_DATA && i_irdy && ti_trdy;
  // a disconnect phase still moves its dword, so it is the last one taken
  wire last_in = xfer_in && (!i_frame || disc);
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ti <= PBW_TI_IDLE;
      cur_addr <= 32'h0000_0000;
      cur_cmd <= 4'h0;
      nonlin <= 1'b0;
      first_put <= 1'b0;
      ti_devsel <= 1'b0;
      ti_trdy <= 1'b0;
    end else begin
      case (ti)
        PBW_TI_IDLE: begin
          if (claim) begin
            ti <= PBW_TI_DATA;
            cur_addr <= ad;
            // only field 11 keeps the invalidate command on the far bus
            cur_cmd <= (is_mwi && wi_fld == 2'b11) ? `PBW_CMD_MWI : `PBW_CMD_MEMWR;
            nonlin <= ad[1:0] != 2'b00;
            first_put <= 1'b1;
            ti_devsel <= 1'b1;
            ti_trdy <= 1'b1;
          end
        end
        PBW_TI_DATA: begin
          if (xfer_in) begin
            cur_addr <= cur_addr + 32'd4;
            first_put <= 1'b0;
            if (last_in) begin
              ti <= PBW_TI_TURN;
              ti_devsel <= 1'b0;
              ti_trdy <= 1'b0;
            end
          end
        end
        PBW_TI_TURN: ti <= PBW_TI_IDLE;
        default: ti <= PBW_TI_IDLE;
      endcase
    end
  end
  // stop is raised with the data phase that ends the burst, so peek ahead
  always_comb begin
    disc = ti == PBW_TI_DATA && (nonlin || at_bound || q_last_room);
  end
  assign I_DEVSEL_N_O = !ti_devsel;
  assign I_TRDY_N_O = !ti_trdy;
  assign I_STOP_N_O = !disc;
  assign I_CTL_OE = ti != PBW_TI_IDLE;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gen_q
      always_ff @(posedge SYS_CLK) begin
        if (xfer_in && wp[AW-1:0] == AW'(g)) begin
          q_data[g] <= ad;
          q_be[g] <= cbe;
          q_addr[g] <= cur_addr;
          q_cmd[g] <= cur_cmd;
        end
      end
      always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
          q_start[g] <= 1'b0;
        end else if (xfer_in && wp[AW-1:0] == AW'(g)) begin
          q_start[g] <= first_put;
        end
      end
    end
  endgenerate

  // master side
  pbw_mst_t mi;
  logic [7:0] lat;
  logic m_frame, m_irdy;
  logic [31:0] m_ad;
  logic [3:0] m_cbe;
  logic drop;
  wire [AW-1:0] rix = rp[AW-1:0];
  wire [AW:0] rp1 = rp + (AW + 1)'(1);
  wire more = (wp != rp1) && !q_start[rp1[AW-1:0]];
  wire m_xfer = mi == PBW_MI_DATA && m_irdy && t_trdy;
  wire lat_out = lat == 8'd0 && !t_gnt;
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mi <= PBW_MI_IDLE;
      rp <= '0;
      wp <= '0;
      lat <= 8'd0;
      m_frame <= 1'b0;
      m_irdy <= 1'b0;
      m_ad <= 32'h0000_0000;
      m_cbe <= 4'hF;
      drop <= 1'b0;
      abort_seen <= 1'b0;
    end else begin
      if (xfer_in) begin
        wp <= wp + (AW + 1)'(1);
      end
      if (acc && PWRITE && PADDR == `PBW_OFS_STATUS) begin
        abort_seen <= 1'b0;
      end
      if (lat != 8'd0 && mi == PBW_MI_DATA) begin
        lat <= lat - 8'd1;
      end
      case (mi)
        PBW_MI_IDLE: begin
          if (drop) begin
            if (!q_empty && !q_start[rix]) begin
              rp <= rp1;
            end else begin
              drop <= 1'b0;
            end
          end else if (!q_empty && t_gnt && t_idle) begin
            mi <= PBW_MI_ADDR;
            m_frame <= 1'b1;
            m_ad <= q_addr[rix];
            m_cbe <= q_cmd[rix];
            lat <= 8'(LAT_TIMER);
          end
        end
        PBW_MI_ADDR: begin
          mi <= PBW_MI_DATA;
          m_irdy <= 1'b1;
          m_ad <= q_data[rix];
          m_cbe <= q_be[rix];
          m_frame <= more;
        end
        PBW_MI_DATA: begin
          if (m_irdy && (t_trdy || t_stop)) begin
            if (t_stop && !t_devsel) begin
              drop <= 1'b1;
              abort_seen <= 1'b1;
              // the head dword is never delivered, so it goes with the rest
              rp <= rp1;
              mi <= PBW_MI_TURN;
              m_frame <= 1'b0;
              m_irdy <= m_frame;
            end else if (!m_frame || t_stop) begin
              if (m_xfer) begin
                rp <= rp1;
              end
              mi <= PBW_MI_TURN;
              m_frame <= 1'b0;
              // frame must rise before irdy falls, so irdy stays for the turn cycle if frame was still asserted
              m_irdy <= m_frame;
            end else begin
              rp <= rp1;
              m_ad <= q_data[rp1[AW-1:0]];
              m_cbe <= q_be[rp1[AW-1:0]];
              // next dword is the last if the queue runs dry, the next entry starts a new transaction, or the timer ran out with grant removed
              m_frame <= (rp1 + (AW + 1)'(1) != wp) && !q_start[rp1[AW-1:0] + AW'(1)] && !lat_out;
            end
          end
        end
        PBW_MI_TURN: begin
          mi <= PBW_MI_IDLE;
          m_irdy <= 1'b0;
        end
        default: mi <= PBW_MI_IDLE;
      endcase
    end
  end
  // a resumed burst must restart at the undelivered address, taken from the head entry's own stored address
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      T_REQ_N <= 1'b1;
    end else begin
      T_REQ_N <= q_empty || drop;
    end
  end
  assign T_AD_O = m_ad;
  assign T_COMMAND_BYTE_ENABLE_O = m_cbe;
  assign T_AD_OE = mi == PBW_MI_ADDR || mi == PBW_MI_DATA;
  assign T_FRAME_N_O = !m_frame;
  assign T_IRDY_N_O = !m_irdy;
  assign T_CTL_OE = mi != PBW_MI_IDLE;

  always_comb begin
    case (PADDR)
      `PBW_OFS_CHIP_CTRL: PRDATA = chip_ctrl;
      `PBW_OFS_WI_CTRL: PRDATA = wi_ctrl;
      `PBW_OFS_LINE_SIZE: PRDATA = {24'h00_0000, line_size};
      `PBW_OFS_STATUS: PRDATA = {22'h00_0000, abort_seen, q_full, 8'(used)};
      default: PRDATA = 32'h0000_0000;
    endcase
  end
endmodule
`default_nettype wire

// >>> tb/pbw_chk.sv
// pbw_chk.sv: port assertions for the posted write bridge
// assumes a bind onto pbw_bridge; one clock, async low reset
`default_nettype none
`include "pbw_consts.svh"
module pbw_chk (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] I_AD,
  input wire logic [3:0] I_COMMAND_BYTE_ENABLE,
  input wire logic I_FRAME_N,
  input wire logic I_IRDY_N,
  input wire logic I_DEVSEL_N_O,
  input wire logic I_TRDY_N_O,
  input wire logic [3:0] T_COMMAND_BYTE_ENABLE_O,
  input wire logic T_FRAME_N_O,
  input wire logic T_IRDY_N_O,
  input wire logic T_REQ_N
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  logic [1:0] wi;
  // shadow of the invalidate field, seen from the register bus
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wi <= 2'h0;
    end else if (PSEL && PENABLE && PWRITE && PADDR == `PBW_OFS_WI_CTRL) begin
      wi <= PWDATA[8:7];
    end
  end
  sequence s_addr;
    $fell(T_FRAME_N_O);
  endsequence
  a_no_bad_claim:
    assert property ($fell(I_FRAME_N) && I_COMMAND_BYTE_ENABLE inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9}
      |=> I_DEVSEL_N_O [*8]) else $error("bad command claimed");
  a_claim_window:
    assert property ($fell(I_FRAME_N) && I_COMMAND_BYTE_ENABLE == `PBW_CMD_MEMWR && I_AD[31:28] == 4'h8
      |-> ##[2:5] !I_DEVSEL_N_O) else $error("window write not claimed");
  a_trdy_devsel:
    assert property ($fell(I_TRDY_N_O) |-> !I_DEVSEL_N_O) else $error("trdy without devsel");
  a_req_follows:
    assert property (!I_IRDY_N && !I_TRDY_N_O |-> ##[0:6] !T_REQ_N) else $error("no bus request");
  a_cmd_legal:
    assert property (s_addr |-> T_COMMAND_BYTE_ENABLE_O inside {`PBW_CMD_MEMWR, `PBW_CMD_MWI})
      else $error("illegal command issued");
  a_mwi_as_write:
    assert property (s_addr and wi != 2'h3 |-> T_COMMAND_BYTE_ENABLE_O != `PBW_CMD_MWI)
      else $error("invalidate not reissued as write");
  a_data_next:
    assert property (s_addr |=> !T_IRDY_N_O) else $error("master wait after address");
  a_last_phase:
    assert property ($rose(T_FRAME_N_O) |-> !T_IRDY_N_O) else $error("frame dropped without irdy");
endmodule
`default_nettype wire

// >>> tb/pbw_tgt_model.sv
// pbw_tgt_model.sv: far-bus target plus one-master arbiter
// assumes the bench resolves pulled-up control lines
`default_nettype none
module pbw_tgt_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic req_n,
  input wire logic hold,
  input wire logic [1:0] mode,
  output logic gnt_n,
  output logic trdy_n,
  output logic stop_n,
  output logic devsel_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] got [$];
  logic [31:0] first;
  logic [3:0] cmd;
  logic act;
  // the bridge sees target lines two edges late, so a phase completes on that view
  logic [1:0] trdy_d, stop_d;
  int tries;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gnt_n <= 1'b1;
      trdy_n <= 1'b1;
      stop_n <= 1'b1;
      devsel_n <= 1'b1;
      act <= 1'b0;
      tries <= 0;
      trdy_d <= 2'b11;
      stop_d <= 2'b11;
    end else begin
      gnt_n <= req_n | hold;
      trdy_d <= {trdy_d[0], trdy_n};
      stop_d <= {stop_d[0], stop_n};
      if (!act && !frame_n) begin
        act <= 1'b1;
        tries <= tries + 1;
        if (got.size() == 0) begin
          first <= ad;
          cmd <= cbe;
        end
        // mode 1 retries, mode 2 aborts
        devsel_n <= (mode == 2'h2);
        trdy_n <= (mode != 2'h0);
        stop_n <= (mode == 2'h0);
      end else if (act) begin
        if (!irdy_n && !trdy_d[1]) got.push_back(ad);
        if (frame_n && (irdy_n || !(trdy_d[1] && stop_d[1]))) begin
          act <= 1'b0;
          devsel_n <= 1'b1;
          trdy_n <= 1'b1;
          stop_n <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// testbench.sv: directed tests of the posted write bridge
// assumes pbw_bridge, pbw_chk and pbw_tgt_model compiled first
`default_nettype none
`include "pbw_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 8;
  localparam logic [31:0] WIN = 32'h8000_0000;
  int failures = 0;
  int checked = 0;
  int k;
  int n0;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, ifr_n = 1, irdy_n = 1, hold = 0, err;
  logic pready, perr, idev_n, itrdy_n, istop_n, tfo_n, tio_n, toe, req_n, gnt_n, ttrdy_n, tstop_n, tdev_n;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, iad = 0, prd, tad, q;
  logic [3:0] icbe = 0, tcbe;
  logic [1:0] mode = 0;
  logic [3:0] bad [7] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9};
  // undriven control lines float high through pull-ups
  wire tfr_n = toe ? tfo_n : 1'b1;
  wire tir_n = toe ? tio_n : 1'b1;
  initial begin
    forever #2 clk = ~clk;
  end
  pbw_bridge #(.DEPTH(DEPTH)) u_pbw_bridge (.SYS_CLK(clk), .RST_B(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(pready), .PSLVERR(perr), .I_AD(iad),
    .I_COMMAND_BYTE_ENABLE(icbe), .I_FRAME_N(ifr_n), .I_IRDY_N(irdy_n), .I_DEVSEL_N_O(idev_n),
    .I_TRDY_N_O(itrdy_n), .I_STOP_N_O(istop_n), .I_CTL_OE(), .T_AD_O(tad), .T_COMMAND_BYTE_ENABLE_O(tcbe),
    .T_AD_OE(), .T_FRAME_N_O(tfo_n), .T_IRDY_N_O(tio_n), .T_CTL_OE(toe), .T_REQ_N(req_n), .T_GNT_N(gnt_n),
    .T_FRAME_N(tfr_n), .T_IRDY_N(tir_n), .T_TRDY_N(ttrdy_n), .T_STOP_N(tstop_n), .T_DEVSEL_N(tdev_n));
  pbw_tgt_model u_pbw_tgt_model (.clk(clk), .rst_n(rst_n), .ad(tad), .cbe(tcbe), .frame_n(tfr_n),
    .irdy_n(tir_n), .req_n(req_n), .hold(hold), .mode(mode), .gnt_n(gnt_n), .trdy_n(ttrdy_n),
    .stop_n(tstop_n), .devsel_n(tdev_n));
  function automatic logic [31:0] dw(input int i);
    return 32'hC0DE_0000 + i;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // initiator burst, one dword a clock as the bridge takes them without waits;
  // k counts dwords taken, a stop ends it at once
  task automatic iwr(input logic [31:0] a, input logic [3:0] c, input int n);
    int t;
    t = 0;
    k = 0;
    @(posedge clk);
    ifr_n <= 1'b0;
    iad <= a;
    icbe <= c;
    @(posedge clk);
    ifr_n <= (n == 1);
    irdy_n <= 1'b0;
    iad <= dw(0);
    icbe <= 4'h0;
    forever begin
      @(posedge clk);
      t++;
      if (itrdy_n === 1'b0) k++;
      if (istop_n === 1'b0 || k == n || t == 24) break;
      if (t < n) begin
        iad <= dw(t);
        ifr_n <= (t == n - 1);
      end
    end
    ifr_n <= 1'b1;
    irdy_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic drained(input int n, input logic [31:0] a, input logic [3:0] c);
    int t;
    t = 0;
    while (u_pbw_tgt_model.got.size() < n && t < 400) begin
      @(posedge clk);
      t++;
    end
    repeat (8) @(posedge clk);
    chk("count", u_pbw_tgt_model.got.size(), n);
    for (int i = 0; i < n; i++) chk("data", u_pbw_tgt_model.got[i], dw(i));
    chk("addr", u_pbw_tgt_model.first, a);
    chk("cmd", u_pbw_tgt_model.cmd, c);
    u_pbw_tgt_model.got.delete();
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, `PBW_OFS_CHIP_CTRL, 0);
    chk("chip_ctrl", q, `PBW_RST_CHIP_CTRL);
    apb(1, `PBW_OFS_WI_CTRL, 32'h0000_0180);
    apb(0, `PBW_OFS_WI_CTRL, 0);
    chk("wi_ctrl", q[8:7], 32'h0000_0003);
    apb(0, 12'h100, 0);
    chk("unmapped", {q[30:0], err}, 32'h0000_0001);
    $display("test registers done");
    apb(1, `PBW_OFS_LINE_SIZE, 4);
    for (int m = 0; m < 3; m++) begin
      apb(1, `PBW_OFS_WI_CTRL, m << 7);
      iwr(WIN, `PBW_CMD_MWI, 2);
      drained(2, WIN, `PBW_CMD_MEMWR);
    end
    apb(1, `PBW_OFS_WI_CTRL, 32'h0000_0180);
    for (int s = 3; s < 5; s++) begin
      apb(1, `PBW_OFS_LINE_SIZE, s);
      iwr(WIN, `PBW_CMD_MWI, 8);
      chk("mwi taken", k, s == 4 ? 4 : 8);
      drained(k, WIN, `PBW_CMD_MWI);
    end
    apb(1, `PBW_OFS_CHIP_CTRL, 2);
    iwr(WIN, `PBW_CMD_MEMWR, 8);
    chk("line stop", k, 4);
    drained(4, WIN, `PBW_CMD_MEMWR);
    apb(1, `PBW_OFS_CHIP_CTRL, 0);
    iwr(WIN | 1, `PBW_CMD_MEMWR, 3);
    chk("nonlinear", k, 1);
    drained(1, WIN | 1, `PBW_CMD_MEMWR);
    foreach (bad[i]) begin
      iwr(WIN, bad[i], 1);
      chk("refused", k, 0);
    end
    $display("test commands done");
    hold <= 1'b1;
    iwr(WIN, `PBW_CMD_MEMWR, 12);
    chk("full stop", k, DEPTH);
    hold <= 1'b0;
    drained(DEPTH, WIN, `PBW_CMD_MEMWR);
    for (int e = 1; e < 3; e++) begin
      n0 = u_pbw_tgt_model.tries;
      mode <= 2'(e);
      iwr(WIN, `PBW_CMD_MEMWR, 2);
      for (int t = 0; t < 200 && u_pbw_tgt_model.tries == n0; t++) @(posedge clk);
      mode <= 2'h0;
      if (e == 1) drained(2, WIN, `PBW_CMD_MEMWR);
    end
    repeat (40) @(posedge clk);
    chk("dropped", u_pbw_tgt_model.got.size(), 0);
    apb(0, `PBW_OFS_STATUS, 0);
    chk("abort flag", q[9], 1);
    apb(1, `PBW_OFS_STATUS, 0);
    apb(0, `PBW_OFS_STATUS, 0);
    chk("abort clear", q[9], 0);
    $display("test termination done");
    end_of_test();
  end
  // whole run needs a few hundred cycles
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    $display("ERROR watchdog exp done got timeout");
    end_of_test();
  end
endmodule
bind pbw_bridge pbw_chk u_pbw_chk (.*);
`default_nettype wire
